// [design/pmp_defines.vh]
`ifndef PMP_DEFINES_VH
`define PMP_DEFINES_VH

// Processor-side register offsets
`define PMP_OFS_MBOX0        8'h20
`define PMP_OFS_MBOX1        8'h21
`define PMP_OFS_MBOX2        8'h22
`define PMP_OFS_STATUS       8'h23
`define PMP_OFS_CONTROL      8'h24

// Host-side two-bit address codes
`define PMP_HADDR_MBOX0      2'b00
`define PMP_HADDR_MBOX2      2'b10
`define PMP_HADDR_STATUS     2'b11

// port_status layout
`define PMP_ST_IRQ           7
`define PMP_ST_ATTN          6
`define PMP_ST_OUT_FULL_LSB  3
`define PMP_ST_IN_FULL_LSB   0
`define PMP_STATUS_RESET     8'h00

// port_control layout
`define PMP_CT_PRIO_LSB      0
`define PMP_CT_PRIO_MSB      1
`define PMP_CT_ENABLE        2
`define PMP_CT_WMASK         8'h1f
`define PMP_CONTROL_RESET    8'h00

// Interrupt vector offset in the internal vector table
`define PMP_IRQ_VECTOR       12'h080

// Boot mode pin code that boots through this port
`define PMP_BOOT_PORT        2'b01

// Sync reset pattern: {alt_cs_n, cs_n, wr_n, rd_n, addr[1:0]}
`define PMP_CTL_SYNC_RESET   6'h3c

`endif

// [design/pmp_pin_sync.v]
`timescale 1ns/1ps
`default_nettype none

module pmp_pin_sync #(
  parameter       W   = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         i_ref_clk,
  input  wire         i_resetn,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_q <= RST[g];
          sync_q <= RST[g];
        end else begin
          meta_q <= i_d[g];
          sync_q <= meta_q;
        end
      end
      assign o_q[g] = sync_q;
    end
  endgenerate

endmodule // pmp_pin_sync

`default_nettype wire

// [design/pmp_mailbox_bank.v]
`timescale 1ns/1ps
`default_nettype none

// Three mailbox bytes: one writer, one reader
module pmp_mailbox_bank (
  input  wire       i_ref_clk,
  input  wire       i_resetn,
  input  wire       i_wr,
  input  wire [1:0] i_wr_idx,
  input  wire [7:0] i_wr_data,
  input  wire [1:0] i_rd_idx,
  output wire [7:0] o_rd_data
);

  reg [7:0] mem_q [0:2];
  integer   k;

  // Data bytes have no defined reset; cleared anyway for clean sims
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (k = 0; k < 3; k = k + 1) begin
        mem_q[k] <= 8'h00;
      end
    end else if (i_wr && (i_wr_idx != 2'b11)) begin
      mem_q[i_wr_idx] <= i_wr_data;
    end
  end

  assign o_rd_data = (i_rd_idx == 2'b11) ? 8'h00 : mem_q[i_rd_idx];

endmodule // pmp_mailbox_bank

`default_nettype wire

// [design/pmp_mailbox_port.v]
`timescale 1ns/1ps
`default_nettype none
`include "pmp_defines.vh"

module pmp_mailbox_port (
  input  wire       i_ref_clk,
  input  wire       i_resetn,
  // Processor register port
  input  wire [7:0] i_cpu_addr,
  input  wire       i_cpu_wr,
  input  wire       i_cpu_rd,
  input  wire [7:0] i_cpu_wdata,
  output wire [7:0] o_cpu_rdata,
  output wire       o_cpu_irq,
  output wire [1:0] o_irq_priority,
  output wire [11:0] o_irq_vector,
  // Boot straps
  input  wire [1:0] i_boot_mode_pins,
  output wire       o_boot_active,
  // Host pins
  input  wire [7:0] i_host_data_bus,
  output wire [7:0] o_host_data_bus,
  output wire       o_host_data_oe_n,
  input  wire [1:0] i_host_addr_bus,
  input  wire       i_host_read_strobe_n,
  input  wire       i_host_write_strobe_n,
  input  wire       i_host_chip_select_n,
  input  wire       i_alt_host_chip_select_n,
  output wire       o_attention_n,
  output wire       o_port_pins_owned
);

  // Synchronised host pins
  wire [5:0] ctl_s;
  wire [7:0] data_s;
  wire [1:0] addr_s;
  wire       rd_n_s;
  wire       wr_n_s;
  wire       cs_n_s;
  wire       alt_cs_n_s;

  pmp_pin_sync #(
    .W   (6),
    .RST (`PMP_CTL_SYNC_RESET)
  ) u_ctl_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_d       ({i_alt_host_chip_select_n, i_host_chip_select_n,
                 i_host_write_strobe_n, i_host_read_strobe_n, i_host_addr_bus}),
    .o_q       (ctl_s)
  );

  pmp_pin_sync #(
    .W   (8),
    .RST (8'h00)
  ) u_data_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_d       (i_host_data_bus),
    .o_q       (data_s)
  );

  assign addr_s     = ctl_s[1:0];
  assign rd_n_s     = ctl_s[2];
  assign wr_n_s     = ctl_s[3];
  assign cs_n_s     = ctl_s[4];
  assign alt_cs_n_s = ctl_s[5];

  // Registers
  reg [7:0]  control_q;
  reg [2:0]  in_full_q;
  reg [2:0]  out_full_q;
  reg        irq_pend_q;
  reg        attn_q;
  reg        rd_prev_q;
  reg        wr_prev_q;
  reg        rd_act_q;
  reg        wr_act_q;
  reg [1:0]  wr_addr_q;
  reg [7:0]  data_last_q;
  reg [7:0]  host_dout_q;
  reg        host_oe_n_q;
  reg [7:0]  cpu_rdata_q;
  reg        cpu_irq_q;
  reg [1:0]  irq_prio_q;
  reg [11:0] irq_vec_q;
  reg        attn_n_q;
  reg        owned_q;
  reg        boot_taken_q;
  reg        boot_q;

  wire [7:0] in_rd_data;
  wire [7:0] out_rd_data;
  wire [7:0] status;
  wire       port_en;
  wire       host_sel;
  wire       host_rd_start;
  wire       host_wr_start;
  wire       host_wr_commit;
  wire       host_rd_end;
  wire       host_access;
  wire       cpu_hit_mbox;
  wire       cpu_hit_status;
  wire       cpu_hit_control;
  wire       cpu_access;
  wire [1:0] cpu_idx;
  wire       host_wr_mbox;
  wire       cpu_wr_mbox;
  wire       cpu_rd_mbox;
  wire       host_rd_mbox;

  // Boot straps override the enable bit
  assign port_en  = control_q[`PMP_CT_ENABLE] | boot_q;
  assign host_sel = port_en & (~cs_n_s | ~alt_cs_n_s);

  assign host_rd_start  = host_sel & rd_prev_q & ~rd_n_s;
  assign host_rd_end    = rd_act_q & rd_n_s;
  assign host_wr_start  = host_sel & wr_prev_q & ~wr_n_s;
  // Select may drop with the strobe, so the start latches it
  assign host_wr_commit = wr_act_q & wr_n_s;
  assign host_access    = host_rd_start | host_wr_commit;

  assign cpu_hit_mbox    = (i_cpu_addr >= `PMP_OFS_MBOX0) && (i_cpu_addr <= `PMP_OFS_MBOX2);
  assign cpu_hit_status  = (i_cpu_addr == `PMP_OFS_STATUS);
  assign cpu_hit_control = (i_cpu_addr == `PMP_OFS_CONTROL);
  assign cpu_idx         = i_cpu_addr[1:0];
  assign cpu_access      = (i_cpu_wr | i_cpu_rd) & (cpu_hit_mbox | cpu_hit_status);

  assign host_wr_mbox = host_wr_commit & (wr_addr_q != `PMP_HADDR_STATUS);
  assign host_rd_mbox = host_rd_start & (addr_s != `PMP_HADDR_STATUS);
  assign cpu_wr_mbox  = i_cpu_wr & cpu_hit_mbox;
  assign cpu_rd_mbox  = i_cpu_rd & cpu_hit_mbox;

  // Input direction: host writes, processor reads
  pmp_mailbox_bank u_in_bank (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_wr      (host_wr_mbox),
    .i_wr_idx  (wr_addr_q),
    .i_wr_data (data_last_q),
    .i_rd_idx  (cpu_idx),
    .o_rd_data (in_rd_data)
  );

  // Output direction: processor writes, host reads
  pmp_mailbox_bank u_out_bank (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_wr      (cpu_wr_mbox),
    .i_wr_idx  (cpu_idx),
    .i_wr_data (i_cpu_wdata),
    .i_rd_idx  (addr_s),
    .o_rd_data (out_rd_data)
  );

  // Bits may change between host samples; pollers must read twice
  assign status = {irq_pend_q, attn_q, out_full_q, in_full_q};

  // Host strobe tracking
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_prev_q   <= 1'b1;
      wr_prev_q   <= 1'b1;
      rd_act_q    <= 1'b0;
      wr_act_q    <= 1'b0;
      wr_addr_q   <= 2'b00;
      data_last_q <= 8'h00;
    end else begin
      rd_prev_q   <= rd_n_s;
      wr_prev_q   <= wr_n_s;
      // Last data seen while the write strobe was still low
      data_last_q <= data_s;
      if (host_rd_start) begin
        rd_act_q  <= 1'b1;
      end else if (host_rd_end) begin
        rd_act_q  <= 1'b0;
      end
      if (host_wr_start) begin
        wr_act_q  <= 1'b1;
        wr_addr_q <= addr_s;
      end else if (host_wr_commit) begin
        wr_act_q  <= 1'b0;
      end
    end
  end

  // Host read data and bus drive
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      host_dout_q <= 8'h00;
      host_oe_n_q <= 1'b1;
    end else begin
      if (host_rd_start) begin
        if (addr_s == `PMP_HADDR_STATUS) begin
          host_dout_q <= status;
        end else begin
          host_dout_q <= out_rd_data;
        end
      end
      // Drive only inside a selected read
      host_oe_n_q <= ~((host_rd_start | rd_act_q) & ~rd_n_s & port_en);
    end
  end

  // Full flags: a set in the same cycle beats the clear
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_flag
      wire in_set;
      wire in_clr;
      wire out_set;
      wire out_clr;
      assign in_set  = host_wr_mbox & (wr_addr_q == g);
      assign in_clr  = cpu_rd_mbox & (cpu_idx == g);
      assign out_set = cpu_wr_mbox & (cpu_idx == g);
      assign out_clr = host_rd_mbox & (addr_s == g);
      always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          in_full_q[g]  <= 1'b0;
          out_full_q[g] <= 1'b0;
        end else begin
          if (in_set) begin
            in_full_q[g] <= 1'b1;
          end else if (in_clr) begin
            in_full_q[g] <= 1'b0;
          end
          if (out_set) begin
            out_full_q[g] <= 1'b1;
          end else if (out_clr) begin
            out_full_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Interrupt and attention: set wins over any clearing access
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_pend_q <= 1'b0;
      attn_q     <= 1'b0;
    end else begin
      if (host_wr_mbox && (wr_addr_q == `PMP_HADDR_MBOX0)) begin
        irq_pend_q <= 1'b1;
      end else if (host_access || cpu_access) begin
        irq_pend_q <= 1'b0;
      end
      if (cpu_wr_mbox && (i_cpu_addr == `PMP_OFS_MBOX0)) begin
        attn_q <= 1'b1;
      end else if (host_access || cpu_access) begin
        attn_q <= 1'b0;
      end
    end
  end

  // Control register and processor read data
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      control_q   <= `PMP_CONTROL_RESET;
      cpu_rdata_q <= 8'h00;
    end else begin
      if (i_cpu_wr && cpu_hit_control) begin
        control_q <= i_cpu_wdata & `PMP_CT_WMASK;
      end
      if (i_cpu_rd) begin
        if (cpu_hit_mbox) begin
          cpu_rdata_q <= in_rd_data;
        end else if (cpu_hit_status) begin
          cpu_rdata_q <= status;
        end else if (cpu_hit_control) begin
          cpu_rdata_q <= control_q;
        end else begin
          cpu_rdata_q <= 8'h00;
        end
      end
    end
  end

  // Strap capture on the first edge after reset release
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      boot_taken_q <= 1'b0;
      boot_q       <= 1'b0;
    end else if (!boot_taken_q) begin
      boot_taken_q <= 1'b1;
      boot_q       <= (i_boot_mode_pins == `PMP_BOOT_PORT);
    end
  end

  // Registered outputs
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cpu_irq_q  <= 1'b0;
      irq_prio_q <= 2'b00;
      irq_vec_q  <= 12'h000;
      attn_n_q   <= 1'b1;
      owned_q    <= 1'b0;
    end else begin
      irq_prio_q <= control_q[`PMP_CT_PRIO_MSB:`PMP_CT_PRIO_LSB];
      // Priority 0 means the interrupt is disabled
      cpu_irq_q  <= irq_pend_q & (control_q[`PMP_CT_PRIO_MSB:`PMP_CT_PRIO_LSB] != 2'b00);
      irq_vec_q  <= `PMP_IRQ_VECTOR;
      attn_n_q   <= ~attn_q;
      owned_q    <= port_en;
    end
  end

  assign o_cpu_rdata      = cpu_rdata_q;
  assign o_cpu_irq        = cpu_irq_q;
  assign o_irq_priority   = irq_prio_q;
  assign o_irq_vector     = irq_vec_q;
  assign o_boot_active    = boot_q;
  assign o_host_data_bus  = host_dout_q;
  assign o_host_data_oe_n = host_oe_n_q;
  assign o_attention_n    = attn_n_q;
  assign o_port_pins_owned = owned_q;

endmodule // pmp_mailbox_port

`default_nettype wire

// [verif/pmp_mailbox_port_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module pmp_mailbox_port_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_cpu_addr,
  input wire logic        i_cpu_wr,
  input wire logic        i_cpu_rd,
  input wire logic [7:0]  o_cpu_rdata,
  input wire logic        o_cpu_irq,
  input wire logic [1:0]  o_irq_priority,
  input wire logic [11:0] o_irq_vector,
  input wire logic        o_host_data_oe_n,
  input wire logic [1:0]  i_host_addr_bus,
  input wire logic        i_host_read_strobe_n,
  input wire logic        i_host_write_strobe_n,
  input wire logic        i_host_chip_select_n,
  input wire logic        i_alt_host_chip_select_n,
  input wire logic        o_attention_n,
  input wire logic        o_port_pins_owned
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_host_wr0;
    (!i_host_write_strobe_n && !i_host_chip_select_n && i_host_addr_bus == 2'b00
      && o_port_pins_owned && o_irq_priority != 2'b00) [*4] ##1 $rose(i_host_write_strobe_n);
  endsequence
  sequence s_cpu_wr0;
    (i_cpu_wr && i_cpu_addr == 8'h20) ##1 (!i_cpu_wr && !i_cpu_rd);
  endsequence
  AST_HOST_WR0_IRQ: assert property (s_host_wr0 |-> ##[2:6] o_cpu_irq)
    else $error("host write of mailbox 0 raised no interrupt");
  AST_CPU_WR0_ATTN: assert property (s_cpu_wr0 |-> ##1 !o_attention_n)
    else $error("processor write of mailbox 0 raised no attention");
  AST_STATUS_WR_CLR: assert property (i_cpu_wr && i_cpu_addr == 8'h23 |-> ##2 !o_cpu_irq)
    else $error("status write left interrupt pending");
  AST_IRQ_PRIO: assert property (o_cpu_irq |-> o_irq_priority != 2'b00)
    else $error("interrupt raised with priority zero");
  AST_VECTOR: assert property ($past(i_resetn) |-> o_irq_vector == 12'h080)
    else $error("interrupt vector wrong");
  AST_UNMAPPED_RD: assert property (i_cpu_rd && (i_cpu_addr < 8'h20 || i_cpu_addr > 8'h24)
    |=> o_cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_OE_NEEDS_CS: assert property ($fell(o_host_data_oe_n) |-> !$past(i_host_read_strobe_n, 2)
    && (!$past(i_host_chip_select_n, 2) || !$past(i_alt_host_chip_select_n, 2)))
    else $error("data bus driven without selected read");
  AST_OE_RELEASE: assert property ($rose(i_host_read_strobe_n) |-> ##[1:6] o_host_data_oe_n)
    else $error("data bus not released after read");
  AST_OWNED_OE: assert property (!o_host_data_oe_n |-> o_port_pins_owned)
    else $error("data bus driven while port disabled");
endmodule // pmp_mailbox_port_checker
bind pmp_mailbox_port pmp_mailbox_port_checker u_pmp_mailbox_port_checker (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_cpu_addr(i_cpu_addr), .i_cpu_wr(i_cpu_wr),
  .i_cpu_rd(i_cpu_rd), .o_cpu_rdata(o_cpu_rdata), .o_cpu_irq(o_cpu_irq),
  .o_irq_priority(o_irq_priority), .o_irq_vector(o_irq_vector),
  .o_host_data_oe_n(o_host_data_oe_n), .i_host_addr_bus(i_host_addr_bus),
  .i_host_read_strobe_n(i_host_read_strobe_n), .i_host_write_strobe_n(i_host_write_strobe_n),
  .i_host_chip_select_n(i_host_chip_select_n),
  .i_alt_host_chip_select_n(i_alt_host_chip_select_n), .o_attention_n(o_attention_n),
  .o_port_pins_owned(o_port_pins_owned));
`default_nettype wire

// [verif/pmp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmp_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_host_data_bus,
  input  wire logic       i_host_data_oe_n,
  output wire logic [7:0] o_host_data_bus,
  output logic      [1:0] o_host_addr_bus,
  output logic            o_host_read_strobe_n,
  output logic            o_host_write_strobe_n,
  output logic            o_host_chip_select_n,
  output logic            o_alt_host_chip_select_n
);
  logic [7:0] drv;
  // Undriven bus shows the inverse of the last value, never a stale match
  assign o_host_data_bus = i_host_data_oe_n ? drv : i_host_data_bus;
  initial begin
    drv = 8'h00;
    o_host_addr_bus = 2'b00;
    {o_host_read_strobe_n, o_host_write_strobe_n} = 2'b11;
    {o_host_chip_select_n, o_alt_host_chip_select_n} = 2'b11;
  end
  // Strobes held six cycles low and six high, beyond the synchroniser delay
  task xfer(input logic wr, input logic [1:0] a, input logic [7:0] d, input logic [1:0] sel,
            output logic [7:0] q);
    @(posedge i_ref_clk);
    o_host_chip_select_n <= ~sel[0];
    o_alt_host_chip_select_n <= ~sel[1];
    o_host_addr_bus <= a;
    if (wr) drv <= d;
    o_host_write_strobe_n <= ~wr;
    o_host_read_strobe_n <= wr;
    repeat (6) @(posedge i_ref_clk);
    q = o_host_data_bus;
    o_host_write_strobe_n <= 1'b1;
    o_host_read_strobe_n <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    o_host_chip_select_n <= 1'b1;
    o_alt_host_chip_select_n <= 1'b1;
    drv <= ~drv;
    #1;
  endtask
endmodule // pmp_host_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_ref_clk, i_resetn, i_cpu_wr, i_cpu_rd;
  logic [7:0]  i_cpu_addr, i_cpu_wdata, q;
  logic [1:0]  i_boot_mode_pins;
  wire  [7:0]  o_cpu_rdata, i_host_data_bus, o_host_data_bus;
  wire  [11:0] o_irq_vector;
  wire  [1:0]  o_irq_priority, i_host_addr_bus;
  wire         o_cpu_irq, o_boot_active, o_host_data_oe_n, o_attention_n, o_port_pins_owned;
  wire         i_host_read_strobe_n, i_host_write_strobe_n;
  wire         i_host_chip_select_n, i_alt_host_chip_select_n;
  int          n_mismatch, comparisons;
  pmp_mailbox_port u_pmp_mailbox_port (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_cpu_addr(i_cpu_addr), .i_cpu_wr(i_cpu_wr), .i_cpu_rd(i_cpu_rd),
    .i_cpu_wdata(i_cpu_wdata), .o_cpu_rdata(o_cpu_rdata), .o_cpu_irq(o_cpu_irq),
    .o_irq_priority(o_irq_priority), .o_irq_vector(o_irq_vector),
    .i_boot_mode_pins(i_boot_mode_pins), .o_boot_active(o_boot_active),
    .i_host_data_bus(i_host_data_bus), .o_host_data_bus(o_host_data_bus),
    .o_host_data_oe_n(o_host_data_oe_n), .i_host_addr_bus(i_host_addr_bus),
    .i_host_read_strobe_n(i_host_read_strobe_n), .i_host_write_strobe_n(i_host_write_strobe_n),
    .i_host_chip_select_n(i_host_chip_select_n),
    .i_alt_host_chip_select_n(i_alt_host_chip_select_n),
    .o_attention_n(o_attention_n), .o_port_pins_owned(o_port_pins_owned));
  pmp_host_model u_pmp_host_model (.i_ref_clk(i_ref_clk), .i_host_data_bus(o_host_data_bus),
    .i_host_data_oe_n(o_host_data_oe_n), .o_host_data_bus(i_host_data_bus),
    .o_host_addr_bus(i_host_addr_bus), .o_host_read_strobe_n(i_host_read_strobe_n),
    .o_host_write_strobe_n(i_host_write_strobe_n), .o_host_chip_select_n(i_host_chip_select_n),
    .o_alt_host_chip_select_n(i_alt_host_chip_select_n));
  task check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cpu_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_cpu_wr <= wr;
    i_cpu_rd <= ~wr;
    i_cpu_addr <= a;
    i_cpu_wdata <= d;
    @(posedge i_ref_clk);
    i_cpu_wr <= 1'b0;
    i_cpu_rd <= 1'b0;
    #1;
  endtask
  task cpu_chk(input logic [7:0] a, input logic [7:0] e);
    cpu_acc(1'b0, a, 8'h00);
    check("cpu_rdata", o_cpu_rdata, e);
  endtask
  task hx(input logic wr, input logic [1:0] a, input logic [7:0] d, input logic [1:0] sel);
    u_pmp_host_model.xfer(wr, a, d, sel, q);
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    {i_resetn, i_cpu_wr, i_cpu_rd, i_cpu_addr, i_cpu_wdata, i_boot_mode_pins} = '0;
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    cpu_chk(8'h23, 8'h00);
    check("boot_active", o_boot_active, 1'b0);
    cpu_chk(8'h24, 8'h00);
    cpu_acc(1'b1, 8'h24, 8'hff);
    cpu_chk(8'h24, 8'h1f);
    cpu_chk(8'h25, 8'h00);
    cpu_acc(1'b1, 8'h24, 8'h05);
    // Priority output lags the control write by one edge
    @(posedge i_ref_clk);
    #1 check("priority", o_irq_priority, 2'b01);
    check("vector", o_irq_vector, 12'h080);
    check("owned", o_port_pins_owned, 1'b1);
    hx(1'b1, 2'b10, 8'ha2, 2'b01);
    hx(1'b1, 2'b01, 8'ha1, 2'b10);
    check("irq", o_cpu_irq, 1'b0);
    hx(1'b1, 2'b00, 8'ha0, 2'b01);
    check("irq", o_cpu_irq, 1'b1);
    cpu_chk(8'h22, 8'ha2);
    cpu_chk(8'h21, 8'ha1);
    check("irq", o_cpu_irq, 1'b0);
    cpu_chk(8'h20, 8'ha0);
    cpu_chk(8'h23, 8'h00);
    hx(1'b1, 2'b00, 8'h5a, 2'b01);
    check("irq", o_cpu_irq, 1'b1);
    cpu_acc(1'b1, 8'h23, 8'hff);
    @(posedge i_ref_clk);
    #1 check("irq", o_cpu_irq, 1'b0);
    cpu_chk(8'h23, 8'h01);
    cpu_acc(1'b1, 8'h21, 8'hb1);
    cpu_acc(1'b1, 8'h20, 8'hb0);
    @(posedge i_ref_clk);
    #1 check("attention_n", o_attention_n, 1'b0);
    hx(1'b0, 2'b01, 8'h00, 2'b01);
    check("host_rdata", q, 8'hb1);
    check("attention_n", o_attention_n, 1'b1);
    hx(1'b0, 2'b00, 8'h00, 2'b10);
    check("host_rdata", q, 8'hb0);
    hx(1'b0, 2'b11, 8'h00, 2'b01);
    check("host_status", q, 8'h01);
    hx(1'b0, 2'b11, 8'h00, 2'b10);
    check("host_status", q, 8'h01);
    cpu_acc(1'b1, 8'h20, 8'hc0);
    hx(1'b1, 2'b11, 8'hff, 2'b01);
    check("attention_n", o_attention_n, 1'b1);
    cpu_chk(8'h23, 8'h09);
    hx(1'b1, 2'b00, 8'h77, 2'b00);
    check("irq", o_cpu_irq, 1'b0);
    cpu_chk(8'h20, 8'h5a);
    // Second reset with boot straps selecting this port
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    i_boot_mode_pins <= 2'b01;
    repeat (3) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 check("boot_active", o_boot_active, 1'b1);
    check("owned", o_port_pins_owned, 1'b1);
    cpu_chk(8'h24, 8'h00);
    hx(1'b1, 2'b01, 8'h3c, 2'b01);
    cpu_chk(8'h21, 8'h3c);
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
